// ---- rtl/bpo_pkg.sv ----
// Constants, register map and carrier types for the bridge protection and output control block.
// Assumes a single 10 MHz system clock and an AXI4-Lite master with 8-bit byte addresses.
package bpo_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h0C;

  // Control register fields
  localparam int CT_VIRT_A = 0;
  localparam int CT_VIRT_B = 1;
  localparam int CT_INPUT_SEL = 2;
  localparam int CT_FULL_BRIDGE = 3;
  localparam int CT_OUT_EN = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0018;
  localparam logic [15:0] CTRL_WMASK = 16'h001F;

  // Status fields; the mask register uses the same positions
  localparam int ST_OVERTEMP = 0;
  localparam int ST_TEMP_WARN = 1;
  localparam int ST_SHORT_A = 4;
  localparam int ST_SHORT_B = 5;
  localparam int ST_OVERVOLT = 8;
  localparam int ST_UNDERVOLT = 9;
  localparam logic [15:0] STATUS_BITS = 16'h0333;
  localparam int MK_PROTECT_OFF = 12;
  localparam logic [15:0] MASK_RESET = 16'h0331;
  localparam logic [15:0] MASK_WMASK = 16'h1333;

  // Synchronised pin vector positions
  localparam int PIN_W = 10;
  localparam int P_DISABLE = 0;
  localparam int P_WAKE = 1;
  localparam int P_DIR_A = 2;
  localparam int P_DIR_B = 3;
  localparam int P_UNDERV = 4;
  localparam int P_OVERV = 5;
  localparam int P_TWARN = 6;
  localparam int P_OVERT = 7;
  localparam int P_SHORT_A = 8;
  localparam int P_SHORT_B = 9;

  // Filters, in the same order as pins P_UNDERV..P_OVERT
  localparam int NUM_FILT = 4;
  localparam int F_UNDERV = 0;
  localparam int F_OVERV = 1;
  localparam int F_TWARN = 2;
  localparam int F_OVERT = 3;
  localparam int CNT_W = 8;

  localparam int CLK_PERIOD_NS = 100;
  localparam int UV_FILT_NS = 10000;
  localparam int OV_FILT_NS = 3000;
  localparam int OT_FILT_NS = 11000;

  function automatic logic [CNT_W-1:0] bpo_cyc_floor(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    bpo_cyc_floor = (c < 1) ? CNT_W'(1) : CNT_W'(c);
  endfunction : bpo_cyc_floor

  localparam logic [CNT_W-1:0] UV_FILT_CYC = bpo_cyc_floor(UV_FILT_NS);
  localparam logic [CNT_W-1:0] OV_FILT_CYC = bpo_cyc_floor(OV_FILT_NS);
  localparam logic [CNT_W-1:0] OT_FILT_CYC = bpo_cyc_floor(OT_FILT_NS);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } bpo_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bpo_axil_rsp_t;

  typedef struct packed {
    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] pin;
    logic [PIN_W-1:0] pin_d;
    logic [NUM_FILT-1:0][CNT_W-1:0] cnt;
    logic [NUM_FILT-1:0] filt;
    logic [15:0] ctrl;
    logic [15:0] mask;
    logic [15:0] status;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic out_a;
    logic out_b;
    logic oe_a_n;
    logic oe_b_n;
    logic fault_n;
  } bpo_state_t;

endpackage : bpo_pkg

// ---- rtl/bpo_bridge_ctrl.sv ----
// Supervision and output control of a two-output power bridge: comparator filters, fault flags,
// fault status pin and the direction-to-output mapping, with an AXI4-Lite register slave.
// Assumes comparator and control pins are asynchronous levels; a floating pin arrives as the level
// its pull gives (disable pulled high, other inputs low).
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module bpo_bridge_ctrl
  import bpo_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire bpo_axil_req_t I_AXI,
  output bpo_axil_rsp_t O_AXI,
  input wire logic I_SLEEP_WAKE_INPUT,
  input wire logic I_OUTPUT_DISABLE_INPUT,
  input wire logic I_DIRECTION_INPUT_A,
  input wire logic I_DIRECTION_INPUT_B,
  input wire logic I_SUPPLY_UNDER_CMP,
  input wire logic I_SUPPLY_OVER_CMP,
  input wire logic I_TEMP_WARN_CMP,
  input wire logic I_TEMP_SHUTDOWN_CMP,
  input wire logic I_SHORT_CMP_A,
  input wire logic I_SHORT_CMP_B,
  output logic O_BRIDGE_OUTPUT_A,
  output logic O_BRIDGE_OUTPUT_A_OE_N,
  output logic O_BRIDGE_OUTPUT_B,
  output logic O_BRIDGE_OUTPUT_B_OE_N,
  output logic O_FAULT_STATUS_OUT_N
);

  localparam logic [NUM_FILT-1:0][CNT_W-1:0] FILT_CYC = {OT_FILT_CYC, OT_FILT_CYC, OV_FILT_CYC, UV_FILT_CYC};

  bpo_state_t s;
  bpo_state_t next_s;
  logic [PIN_W-1:0] pins_raw;
  logic aw_take;
  logic ar_take;

  // Word decode shared by the write and read paths; anything else is unmapped
  function automatic logic bpo_mapped(input logic [ADDR_W-1:0] a);
    bpo_mapped = (a[ADDR_W-1:4] == '0) && (a[1:0] == 2'h0);
  endfunction : bpo_mapped

  function automatic logic [15:0] bpo_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb, input logic [15:0] wm);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & wm;
    bpo_merge = (old & ~m) | (d[15:0] & m);
  endfunction : bpo_merge

  assign pins_raw = {I_SHORT_CMP_B, I_SHORT_CMP_A, I_TEMP_SHUTDOWN_CMP, I_TEMP_WARN_CMP, I_SUPPLY_OVER_CMP,
                     I_SUPPLY_UNDER_CMP, I_DIRECTION_INPUT_B, I_DIRECTION_INPUT_A, I_SLEEP_WAKE_INPUT,
                     I_OUTPUT_DISABLE_INPUT};

  // Both address and data must be present; the slave never holds half a write
  assign aw_take = I_AXI.awvalid && I_AXI.wvalid && !s.bvalid;
  assign ar_take = I_AXI.arvalid && !s.rvalid;

  always_comb begin
    logic awake;
    logic full;
    logic dir_a;
    logic dir_b;
    logic want_a;
    logic want_b;
    logic off_all;
    logic cut_a;
    logic cut_b;
    logic release_pulse;
    logic [15:0] clr;
    logic [15:0] set;
    logic [15:0] shown;
    awake = 1'b0;
    full = 1'b0;
    dir_a = 1'b0;
    dir_b = 1'b0;
    want_a = 1'b0;
    want_b = 1'b0;
    off_all = 1'b0;
    cut_a = 1'b0;
    cut_b = 1'b0;
    release_pulse = 1'b0;
    clr = '0;
    set = '0;
    shown = '0;
    next_s = s;

    // The first stage is read only by the second
    next_s.meta = pins_raw;
    next_s.pin = s.meta;
    next_s.pin_d = s.pin;

    for (int i = 0; i < NUM_FILT; i++) begin
      if (s.pin[P_UNDERV + i] != s.filt[i]) begin
        if (s.cnt[i] + CNT_W'(1) >= FILT_CYC[i]) begin
          next_s.filt[i] = s.pin[P_UNDERV + i];
          next_s.cnt[i] = '0;
        end else begin
          next_s.cnt[i] = s.cnt[i] + CNT_W'(1);
        end
      end else begin
        next_s.cnt[i] = '0;
      end
    end

    awake = s.pin[P_WAKE];
    full = s.ctrl[CT_FULL_BRIDGE];

    // any toggle of the disable or wake pin releases latched faults
    release_pulse = (s.pin[P_DISABLE] ^ s.pin_d[P_DISABLE]) | (s.pin[P_WAKE] ^ s.pin_d[P_WAKE]);

    if (awake) begin
      set[ST_OVERTEMP] = s.filt[F_OVERT];
      set[ST_OVERVOLT] = s.filt[F_OVERV];
      set[ST_UNDERVOLT] = s.filt[F_UNDERV];
      set[ST_SHORT_A] = s.pin[P_SHORT_A];
      set[ST_SHORT_B] = s.pin[P_SHORT_B];
    end

    // AXI write channel
    if (s.bvalid && I_AXI.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (aw_take) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (!bpo_mapped(I_AXI.awaddr)) begin
        next_s.bresp = RESP_SLVERR;
      end else if (I_AXI.awaddr == OFS_CTRL) begin
        next_s.ctrl = bpo_merge(s.ctrl, I_AXI.wdata, I_AXI.wstrb, CTRL_WMASK);
      end else if (I_AXI.awaddr == OFS_MASK) begin
        next_s.mask = bpo_merge(s.mask, I_AXI.wdata, I_AXI.wstrb, MASK_WMASK);
      end else if (I_AXI.awaddr == OFS_CLEAR) begin
        clr = bpo_merge('0, I_AXI.wdata, I_AXI.wstrb, STATUS_BITS);
      end
    end
    if (release_pulse) begin
      clr = STATUS_BITS;
    end

    // set wins over a same-cycle clear
    next_s.status = (s.status & ~clr) | set;

    // warning bit reports the live filtered level, never latched
    shown = s.status;
    shown[ST_TEMP_WARN] = s.filt[F_TWARN] & awake;

    // AXI read channel
    if (s.rvalid && I_AXI.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      if (!bpo_mapped(I_AXI.araddr)) begin
        next_s.rresp = RESP_SLVERR;
      end else if (I_AXI.araddr == OFS_CTRL) begin
        next_s.rdata = {16'h0000, s.ctrl};
      end else if (I_AXI.araddr == OFS_MASK) begin
        next_s.rdata = {16'h0000, s.mask};
      end else if (I_AXI.araddr == OFS_STATUS) begin
        next_s.rdata = {16'h0000, shown};
      end
    end

    // virtual inputs replace the direction pins
    dir_a = s.ctrl[CT_INPUT_SEL] ? s.ctrl[CT_VIRT_A] : s.pin[P_DIR_A];
    dir_b = s.ctrl[CT_INPUT_SEL] ? s.ctrl[CT_VIRT_B] : s.pin[P_DIR_B];

    if (full) begin
      if (!dir_b) begin
        want_a = 1'b1;
        want_b = 1'b1;
      end else begin
        want_a = dir_a;
        want_b = !dir_a;
      end
      if (s.filt[F_OVERV] && !s.mask[MK_PROTECT_OFF]) begin
        want_a = 1'b1;
        want_b = 1'b1;
      end
    end else begin
      want_a = dir_a;
      want_b = dir_b;
    end

    // enable bit and disable pin gate the drive
    off_all = !awake || !s.ctrl[CT_OUT_EN] || s.pin[P_DISABLE] || s.filt[F_UNDERV] || s.status[ST_OVERTEMP];
    // short cuts both in full bridge, one in half bridge
    cut_a = full ? (s.status[ST_SHORT_A] | s.status[ST_SHORT_B]) : s.status[ST_SHORT_A];
    cut_b = full ? (s.status[ST_SHORT_A] | s.status[ST_SHORT_B]) : s.status[ST_SHORT_B];

    next_s.oe_a_n = off_all || cut_a;
    next_s.oe_b_n = off_all || cut_b;
    next_s.out_a = want_a && !next_s.oe_a_n;
    next_s.out_b = want_b && !next_s.oe_b_n;

    // mask bit one lets fault through
    next_s.fault_n = !awake || !(s.pin[P_DISABLE] || |(shown & s.mask & STATUS_BITS));
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.mask <= MASK_RESET;
      s.oe_a_n <= 1'b1;
      s.oe_b_n <= 1'b1;
      s.fault_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    O_AXI = '0;
    O_AXI.awready = aw_take;
    O_AXI.wready = aw_take;
    O_AXI.bvalid = s.bvalid;
    O_AXI.bresp = s.bresp;
    O_AXI.arready = !s.rvalid;
    O_AXI.rvalid = s.rvalid;
    O_AXI.rdata = s.rdata;
    O_AXI.rresp = s.rresp;
  end

  assign O_BRIDGE_OUTPUT_A = s.out_a;
  assign O_BRIDGE_OUTPUT_B = s.out_b;
  assign O_BRIDGE_OUTPUT_A_OE_N = s.oe_a_n;
  assign O_BRIDGE_OUTPUT_B_OE_N = s.oe_b_n;
  assign O_FAULT_STATUS_OUT_N = s.fault_n;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_NRST);

  logic drive_ok;
  assign drive_ok = s.pin[P_WAKE] && !s.pin[P_DISABLE] && s.ctrl[CT_OUT_EN] && !s.filt[F_UNDERV]
                    && s.status[ST_OVERTEMP] == 1'b0 && s.status[ST_SHORT_A] == 1'b0
                    && s.status[ST_SHORT_B] == 1'b0;

  a_sleep_outputs: assert property (!s.pin[P_WAKE] |=> O_BRIDGE_OUTPUT_A_OE_N && O_BRIDGE_OUTPUT_B_OE_N
    && O_FAULT_STATUS_OUT_N)
    else $error("sleep did not tri-state outputs or release status pin");

  a_disable_outputs: assert property (s.pin[P_WAKE] && s.pin[P_DISABLE] |=>
    O_BRIDGE_OUTPUT_A_OE_N && O_BRIDGE_OUTPUT_B_OE_N && !O_FAULT_STATUS_OUT_N)
    else $error("disable pin high did not tri-state and pull status low");

  a_undervolt_off: assert property (s.filt[F_UNDERV] |=> O_BRIDGE_OUTPUT_A_OE_N && O_BRIDGE_OUTPUT_B_OE_N)
    else $error("outputs driven during undervoltage");

  a_undervolt_qual: assert property ($rose(s.filt[F_UNDERV]) |-> $past(s.cnt[F_UNDERV]) == UV_FILT_CYC - 8'h01
    && $past(s.pin[P_UNDERV]))
    else $error("undervoltage qualified after the wrong count");

  a_undervolt_recover: assert property ($fell(s.filt[F_UNDERV]) |-> $past(s.cnt[F_UNDERV]) == UV_FILT_CYC - 8'h01)
    else $error("undervoltage recovery qualified after the wrong count");

  a_overvolt_flag: assert property ($rose(s.filt[F_OVERV]) && s.pin[P_WAKE] |=> s.status[ST_OVERVOLT])
    else $error("overvoltage flag not set");

  a_overvolt_freewheel: assert property (drive_ok && s.ctrl[CT_FULL_BRIDGE] && s.filt[F_OVERV]
    && !s.mask[MK_PROTECT_OFF] |=> O_BRIDGE_OUTPUT_A && O_BRIDGE_OUTPUT_B && !O_BRIDGE_OUTPUT_A_OE_N)
    else $error("full bridge overvoltage did not freewheel high");

  a_overtemp_latch: assert property (s.status[ST_OVERTEMP] |=> O_BRIDGE_OUTPUT_A_OE_N && O_BRIDGE_OUTPUT_B_OE_N)
    else $error("outputs driven with overtemperature latched");

  a_half_follow: assert property (drive_ok && !s.ctrl[CT_FULL_BRIDGE] && !s.ctrl[CT_INPUT_SEL] |=>
    O_BRIDGE_OUTPUT_A == $past(s.pin[P_DIR_A]) && O_BRIDGE_OUTPUT_B == $past(s.pin[P_DIR_B]))
    else $error("half bridge output does not follow its input");

  a_overtemp_flag: assert property ($rose(s.filt[F_OVERT]) && s.pin[P_WAKE] |=> s.status[ST_OVERTEMP])
    else $error("overtemperature flag not set");

  a_undervolt_flag: assert property (s.filt[F_UNDERV] && s.pin[P_WAKE] |=> s.status[ST_UNDERVOLT])
    else $error("undervoltage flag not held");

  a_warn_live: assert property (ar_take && I_AXI.araddr == OFS_STATUS |=>
    s.rdata[ST_TEMP_WARN] == $past(s.filt[F_TWARN] && s.pin[P_WAKE]))
    else $error("temperature warning bit does not show the live level");

  a_flag_hold: assert property (s.status[ST_OVERVOLT] && s.pin[P_WAKE] == s.pin_d[P_WAKE]
    && s.pin[P_DISABLE] == s.pin_d[P_DISABLE] && !(aw_take && I_AXI.awaddr == OFS_CLEAR) |=> s.status[ST_OVERVOLT])
    else $error("overvoltage flag dropped without a clear");

  a_release_clear: assert property ((s.pin[P_WAKE] != s.pin_d[P_WAKE] || s.pin[P_DISABLE] != s.pin_d[P_DISABLE])
    && !s.pin[P_SHORT_A] && !s.pin[P_SHORT_B] && !s.filt[F_UNDERV] && !s.filt[F_OVERV] && !s.filt[F_OVERT]
    |=> s.status == 16'h0000)
    else $error("pin toggle did not release the latched status");

  a_enable_bit: assert property (!s.ctrl[CT_OUT_EN] |=> O_BRIDGE_OUTPUT_A_OE_N && O_BRIDGE_OUTPUT_B_OE_N)
    else $error("outputs driven with the enable bit clear");

  a_full_map: assert property (drive_ok && s.ctrl[CT_FULL_BRIDGE] && !s.ctrl[CT_INPUT_SEL] && s.pin[P_DIR_B]
    && !s.filt[F_OVERV] |=> O_BRIDGE_OUTPUT_A == $past(s.pin[P_DIR_A]) && O_BRIDGE_OUTPUT_B == !$past(s.pin[P_DIR_A]))
    else $error("full bridge forward or reverse mapping wrong");

  a_full_freewheel: assert property (drive_ok && s.ctrl[CT_FULL_BRIDGE] && !s.ctrl[CT_INPUT_SEL]
    && !s.pin[P_DIR_B] |=> O_BRIDGE_OUTPUT_A && O_BRIDGE_OUTPUT_B)
    else $error("full bridge with input B low did not freewheel high");

  a_virtual_input: assert property (drive_ok && s.ctrl[CT_FULL_BRIDGE] && s.ctrl[CT_INPUT_SEL]
    && s.ctrl[CT_VIRT_B] && !s.filt[F_OVERV] |=> O_BRIDGE_OUTPUT_A == $past(s.ctrl[CT_VIRT_A])
    && O_BRIDGE_OUTPUT_B == !$past(s.ctrl[CT_VIRT_A]))
    else $error("virtual direction bits not used in place of the pins");

  a_protect_off: assert property (drive_ok && s.ctrl[CT_FULL_BRIDGE] && !s.ctrl[CT_INPUT_SEL] && s.pin[P_DIR_B]
    && s.filt[F_OVERV] && s.mask[MK_PROTECT_OFF] |=> O_BRIDGE_OUTPUT_A == $past(s.pin[P_DIR_A]))
    else $error("protect-off bit did not suppress the overvoltage freewheel");

  a_short_full: assert property (s.ctrl[CT_FULL_BRIDGE] && (s.status[ST_SHORT_A] || s.status[ST_SHORT_B]) |=>
    O_BRIDGE_OUTPUT_A_OE_N && O_BRIDGE_OUTPUT_B_OE_N)
    else $error("full bridge short did not cut both outputs");

  a_short_half: assert property (!s.ctrl[CT_FULL_BRIDGE] && s.status[ST_SHORT_B] |=> O_BRIDGE_OUTPUT_B_OE_N)
    else $error("half bridge short did not cut its own output");

  a_fault_masked: assert property (s.pin[P_WAKE] && (s.status & s.mask & STATUS_BITS) != 16'h0000 |=>
    !O_FAULT_STATUS_OUT_N)
    else $error("unmasked fault did not pull the status pin low");

  a_fault_quiet: assert property (s.pin[P_WAKE] && !s.pin[P_DISABLE] && s.status == 16'h0000
    && !s.filt[F_TWARN] |=> O_FAULT_STATUS_OUT_N)
    else $error("status pin low with no fault present");

  c_undervolt: cover property ($rose(s.filt[F_UNDERV]));
  c_freewheel: cover property (s.filt[F_OVERV] && s.ctrl[CT_FULL_BRIDGE] && drive_ok);
  c_overtemp: cover property ($rose(s.status[ST_OVERTEMP]));
  c_axi_write: cover property (aw_take && I_AXI.awaddr == OFS_CLEAR);
  c_protect_off: cover property (s.filt[F_OVERV] && s.mask[MK_PROTECT_OFF] && s.ctrl[CT_FULL_BRIDGE]);

endmodule : bpo_bridge_ctrl

// ---- testbench/bpo_host.sv ----
// Host model: the controlling microcontroller's side of the AXI4-Lite register bus.
// Assumes one clock; the bench calls these tasks one transfer at a time.
`timescale 1ns/1ps

module bpo_host
  import bpo_pkg::*;
(
  input wire logic i_clk,
  input wire bpo_axil_rsp_t i_rsp,
  output bpo_axil_req_t o_req
);
  initial begin
    o_req = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge i_clk);
    o_req.awvalid <= 1'b1;
    o_req.awaddr <= a;
    o_req.wvalid <= 1'b1;
    o_req.wdata <= d;
    o_req.wstrb <= 4'hF;
    o_req.bready <= 1'b1;
    do @(posedge i_clk); while (i_rsp.awready !== 1'b1);
    // Released payload is scrambled so a stale value is never mistaken for a live one
    o_req.awvalid <= 1'b0;
    o_req.wvalid <= 1'b0;
    o_req.awaddr <= ~a;
    o_req.wdata <= ~d;
    while (i_rsp.bvalid !== 1'b1) @(posedge i_clk);
    resp = i_rsp.bresp;
    o_req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge i_clk);
    o_req.arvalid <= 1'b1;
    o_req.araddr <= a;
    o_req.rready <= 1'b1;
    do @(posedge i_clk); while (i_rsp.arready !== 1'b1);
    o_req.arvalid <= 1'b0;
    o_req.araddr <= ~a;
    while (i_rsp.rvalid !== 1'b1) @(posedge i_clk);
    d = i_rsp.rdata;
    resp = i_rsp.rresp;
    o_req.rready <= 1'b0;
  endtask : rd
endmodule : bpo_host

// ---- testbench/tb_top.sv ----
// Self-checking bench for the bridge protection block: scenario tasks drive pins and registers.
// Assumes the host model in bpo_host.sv; pins change by non-blocking assignment at rising edges.
`timescale 1ns/1ps

module tb_top
  import bpo_pkg::*;
;
  localparam int UVN = int'(UV_FILT_CYC);
  localparam int OVN = int'(OV_FILT_CYC);
  localparam int OTN = int'(OT_FILT_CYC);
  logic clk, rst_n, wake, dis, dir_a, dir_b, uv, ov, tw, ot, sh_a, sh_b;
  logic o_a, oe_a_n, o_b, oe_b_n, fault_n;
  bpo_axil_req_t axi_req;
  bpo_axil_rsp_t axi_rsp;
  int errors, cmp_count;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  bpo_bridge_ctrl i_dut (.I_SYS_CLK(clk), .I_NRST(rst_n), .I_AXI(axi_req), .O_AXI(axi_rsp),
    .I_SLEEP_WAKE_INPUT(wake), .I_OUTPUT_DISABLE_INPUT(dis), .I_DIRECTION_INPUT_A(dir_a),
    .I_DIRECTION_INPUT_B(dir_b), .I_SUPPLY_UNDER_CMP(uv), .I_SUPPLY_OVER_CMP(ov), .I_TEMP_WARN_CMP(tw),
    .I_TEMP_SHUTDOWN_CMP(ot), .I_SHORT_CMP_A(sh_a), .I_SHORT_CMP_B(sh_b), .O_BRIDGE_OUTPUT_A(o_a),
    .O_BRIDGE_OUTPUT_A_OE_N(oe_a_n), .O_BRIDGE_OUTPUT_B(o_b), .O_BRIDGE_OUTPUT_B_OE_N(oe_b_n),
    .O_FAULT_STATUS_OUT_N(fault_n));
  bpo_host i_host (.i_clk(clk), .i_rsp(axi_rsp), .o_req(axi_req));

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word

  task automatic chk_out(input logic a, input logic b, input logic oea, input logic oeb, input logic f);
    chk_bit("out_a", a, o_a);
    chk_bit("out_b", b, o_b);
    chk_bit("oe_a_n", oea, oe_a_n);
    chk_bit("oe_b_n", oeb, oe_b_n);
    chk_bit("fault_n", f, fault_n);
  endtask : chk_out

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_host.wr(a, d, r);
    chk_word("bresp", 32'(RESP_OKAY), 32'(r));
  endtask : wr_ok

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    chk_word("rdata", e, d);
    chk_word("rresp", 32'(er), 32'(r));
  endtask : rd_chk

  // Host-side release path: write ones to the clear register
  // AXI4-Lite register release
  task automatic clr(input logic [31:0] bits);
    wr_ok(OFS_CLEAR, bits);
  endtask : clr

  task automatic t_reset;
    cyc(5);
    chk_out(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    rd_chk(OFS_CTRL, 32'h0000_0018, RESP_OKAY);
    rd_chk(OFS_MASK, 32'h0000_0331, RESP_OKAY);
    rd_chk(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    rd_chk(8'h40, 32'h0000_0000, RESP_SLVERR);
  endtask : t_reset

  task automatic t_modes;
    wr_ok(OFS_CTRL, 32'h0000_0010);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      dir_a <= i[0];
      dir_b <= i[1];
      cyc(5);
      chk_out(i[0], i[1], 1'b0, 1'b0, 1'b1);
    end
    // Second half of the loop swaps the pins for the virtual bits, with pins set opposite
    for (int i = 0; i < 8; i++) begin
      wr_ok(OFS_CTRL, 32'h18 | (i[2] ? (32'h4 | 32'(i[1:0])) : 32'h0));
      @(posedge clk);
      dir_a <= i[2] ? !i[0] : i[0];
      dir_b <= i[2] ? !i[1] : i[1];
      cyc(5);
      chk_out(i[1] ? i[0] : 1'b1, i[1] ? !i[0] : 1'b1, 1'b0, 1'b0, 1'b1);
    end
  endtask : t_modes

  task automatic t_enable;
    wr_ok(OFS_CTRL, 32'h0000_0008);
    cyc(5);
    chk_out(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    wr_ok(OFS_CTRL, 32'h0000_0018);
    @(posedge clk);
    dis <= 1'b1;
    cyc(5);
    chk_out(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    dis <= 1'b0;
    wake <= 1'b0;
    cyc(5);
    chk_out(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    @(posedge clk);
    wake <= 1'b1;
    dir_a <= 1'b0;
    dir_b <= 1'b1;
    cyc(5);
    chk_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
  endtask : t_enable

  task automatic t_uv;
    // Two runs short of the filter time, split by a brief drop, must not trip
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      uv <= 1'b1;
      repeat (UVN - 10) @(posedge clk);
      uv <= 1'b0;
      cyc(2);
    end
    chk_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    @(posedge clk);
    uv <= 1'b1;
    cyc(UVN + 10);
    chk_out(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    rd_chk(OFS_STATUS, 32'h0000_0200, RESP_OKAY);
    @(posedge clk);
    uv <= 1'b0;
    cyc(UVN - 10);
    chk_out(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    cyc(20);
    chk_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    clr(32'h0000_0200);
    cyc(3);
    chk_bit("fault_n", 1'b1, fault_n);
  endtask : t_uv

  task automatic t_ov;
    logic [31:0] ctl [3] = '{32'h18, 32'h10, 32'h18};
    logic [31:0] msk [3] = '{32'h331, 32'h331, 32'h1331};
    for (int k = 0; k < 3; k++) begin
      wr_ok(OFS_CTRL, ctl[k]);
      wr_ok(OFS_MASK, msk[k]);
      @(posedge clk);
      ov <= 1'b1;
      cyc(OVN + 10);
      chk_out(k == 0, 1'b1, 1'b0, 1'b0, 1'b0);
      rd_chk(OFS_STATUS, 32'h0000_0100, RESP_OKAY);
      @(posedge clk);
      ov <= 1'b0;
      cyc(OVN + 10);
      chk_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      clr(32'h0000_0100);
      cyc(3);
      chk_bit("fault_n", 1'b1, fault_n);
    end
    wr_ok(OFS_MASK, 32'h0000_0331);
    wr_ok(OFS_CTRL, 32'h0000_0018);
  endtask : t_ov

  task automatic t_temp;
    @(posedge clk);
    ot <= 1'b1;
    cyc(OTN + 10);
    chk_out(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    rd_chk(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
    @(posedge clk);
    ot <= 1'b0;
    cyc(OTN + 10);
    chk_out(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    dis <= 1'b1;
    cyc(5);
    @(posedge clk);
    dis <= 1'b0;
    cyc(5);
    chk_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    @(posedge clk);
    tw <= 1'b1;
    cyc(OTN + 10);
    chk_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000_0002, RESP_OKAY);
    @(posedge clk);
    tw <= 1'b0;
    cyc(OTN + 10);
    rd_chk(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
  endtask : t_temp

  task automatic t_short;
    @(posedge clk);
    sh_a <= 1'b1;
    cyc(5);
    @(posedge clk);
    sh_a <= 1'b0;
    cyc(5);
    chk_out(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    rd_chk(OFS_STATUS, 32'h0000_0010, RESP_OKAY);
    @(posedge clk);
    wake <= 1'b0;
    cyc(5);
    @(posedge clk);
    wake <= 1'b1;
    cyc(5);
    chk_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    wr_ok(OFS_CTRL, 32'h0000_0010);
    @(posedge clk);
    sh_b <= 1'b1;
    cyc(5);
    chk_out(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    sh_b <= 1'b0;
    // Let the dropped short clear the synchroniser, else the set beats the clear
    cyc(3);
    clr(32'h0000_0020);
    cyc(5);
    chk_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    wr_ok(OFS_MASK, 32'h0000_0301);
    @(posedge clk);
    sh_b <= 1'b1;
    cyc(5);
    chk_out(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    @(posedge clk);
    sh_b <= 1'b0;
    cyc(3);
    clr(32'h0000_0020);
  endtask : t_short

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    {rst_n, dis, dir_a, dir_b, uv, ov, tw, ot, sh_a, sh_b} = '0;
    wake = 1'b1;
    errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_enable();
    t_uv();
    t_ov();
    t_temp();
    t_short();
    report_and_stop();
  end
endmodule : tb_top
